// File: scan_trigger_sync_port_map.vh
// register map, reset values and timing constants of the trigger port
`ifndef SCAN_TRIGGER_SYNC_PORT_MAP_VH
`define SCAN_TRIGGER_SYNC_PORT_MAP_VH

`define REG_CTRL 8'h00
`define REG_PIX_HALF 8'h04
`define REG_LINE_PIX 8'h08
`define REG_LINE_GAP 8'h0c
`define REG_FRAME_LINES 8'h10
`define REG_STACK_FRAMES 8'h14
`define REG_TRIG_OUT 8'h18
`define REG_TRIG_EVT 8'h1c
`define REG_STATUS 8'h20

`define CTRL_RUN_BIT 0
`define CTRL_PIEZO_BIT 1
`define STAT_CONN_BIT 0
`define STAT_RUN_BIT 1
`define STAT_LVL_LSB 2
`define STAT_PEND_BIT 6
`define TRIG_UNTIMED_LSB 8

`define RST_CTRL 2'h0
`define RST_PIX_HALF 16'h0032
`define RST_LINE_PIX 16'h0200
`define RST_LINE_GAP 16'h0020
`define RST_FRAME_LINES 16'h0200
`define RST_STACK_FRAMES 16'h0001
`define RST_TRIG_OUT 12'h000

`define MARKER_LEAD_PIX 16'h0010
`define CLK_PER_MS 100000
`define TRIG_OUT_LAT_MS 8
`define TRIG_IN_LAT_MS 16
`define LED_HOLD_MS 500
// the same latencies in core clock cycles, sized for their counters
`define TRIG_OUT_LAT_CYC 24'h0c3500
`define TRIG_IN_LAT_CYC 24'h186a00
`define LED_HOLD_CYC 26'h2faf080

`endif

// File: edge_sync.v
// two-flop synchroniser with edge pulses for asynchronous pins
`timescale 1ns/1ns
module edge_sync #(
   parameter W = 1
) (
   input wire core_clk_i,
   input wire sys_rst_i,
   input wire [W-1:0] async_i,
   output wire [W-1:0] level_o,
   output wire [W-1:0] rise_o,
   output wire [W-1:0] fall_o
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   reg [W-1:0] prev_q;

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
         prev_q <= {W{1'b0}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o = sync_q & ~prev_q;
   assign fall_o = prev_q & ~sync_q;
endmodule

// File: led_activity.v
// activity indicator: stretches short pulses, blinks on fast toggling
`timescale 1ns/1ns
module led_activity #(
   parameter [25:0] HOLD_CYC = 26'd50000000
) (
   input wire core_clk_i,
   input wire sys_rst_i,
   input wire sig_i,
   input wire enable_i,
   output wire led_o
);
   reg led_q;
   reg prev_q;
   reg pend_q;
   reg [25:0] hold_q;
   wire edge_seen;

   assign edge_seen = sig_i ^ prev_q;

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         led_q <= 1'b0;
         prev_q <= 1'b0;
         pend_q <= 1'b0;
         hold_q <= 26'h0000000;
      end else begin
         prev_q <= sig_i;
         if (hold_q != 26'h0000000) begin
            hold_q <= hold_q - 26'h0000001;
            // a whole pulse inside the hold still needs to be shown
            if (edge_seen) begin
               pend_q <= 1'b1;
            end
         // RULE14 toggle per hold
         end else if (sig_i != led_q || pend_q) begin
            led_q <= ~led_q;
            pend_q <= 1'b0;
            // RULE15 RULE16 hold 500 ms
            hold_q <= HOLD_CYC;
         end
      end
   end

   // RULE17 idle follows level
   assign led_o = led_q & enable_i;
endmodule

// File: scan_trigger_sync_port.v
// pixel strobe, scan markers, trigger outputs/inputs and activity leds
// Overview of operation
// RULE1: pixel strobe is a symmetric square wave, half period high, half low.
// RULE2: line, frame and stack markers start 16 pixels before image pixels.
// RULE3: each marker equals the strobe but for a single pixel only.
// RULE4: grabbing window high while a line's data capture runs.
// RULE5: stack marker only at stack start and only with piezo focusing.
// RULE6: markers and grabbing come from hardware timing, hidden from software.
// RULE7: eight outputs timed to the host stream; four are software triggers.
// RULE8: four asynchronous trigger inputs, each able to raise an interrupt.
// RULE9: a falling edge on a trigger input raises an interrupt request.
// RULE10: pulses wider than 50 ns on trigger inputs are detected.
// RULE11: software trigger request reaches its output after about 8 ms.
// RULE12: trigger input edge reaches software after about 16 ms.
// RULE13: grounded connector-detect pin is reported as connector attached.
// RULE14: an led blinks when its signal toggles faster than 2 Hz.
// RULE15: a high pulse under 500 ms lights its led for 500 ms.
// RULE16: a low pulse under 500 ms darkens its led for 500 ms.
// RULE17: a level held over 500 ms is followed directly by the led.
// RULE18: leds react to pulses over 30 ns and rates below 30 MHz.
// RULE19: one panel switch enables or disables all leds together.
// RULE20: trigger inputs pass two flip-flops before falling-edge detection.
`timescale 1ns/1ns
`include "scan_trigger_sync_port_map.vh"
module scan_trigger_sync_port #(
   parameter [23:0] OUT_LAT_CYC = `TRIG_OUT_LAT_CYC,
   parameter [23:0] IN_LAT_CYC = `TRIG_IN_LAT_CYC,
   parameter [25:0] LED_HOLD_CYC = `LED_HOLD_CYC,
   parameter NUM_LED = 10
) (
   input wire core_clk_i,
   input wire sys_rst_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   input wire [7:0] s_axi_awaddr_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   output wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   output wire [1:0] s_axi_bresp_o,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   input wire [7:0] s_axi_araddr_i,
   output wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0] s_axi_rresp_o,
   input wire stream_clk_i,
   input wire [3:0] trigger_input_i,
   input wire conn_detect_n_i,
   input wire led_enable_switch_i,
   output wire pixel_strobe_o,
   output wire line_marker_o,
   output wire frame_marker_o,
   output wire stack_marker_o,
   output wire grab_window_o,
   output wire [7:0] timed_output_o,
   output wire [3:0] untimed_output_o,
   output wire trig_irq_o,
   output wire [NUM_LED-1:0] led_o
);
   wire [3:0] trig_lvl, trig_fall;
   wire [2:0] misc_lvl, misc_rise;

   // RULE20 two-flop sync
   edge_sync #(.W(4)) u_trig_sync (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(trigger_input_i),
      .level_o(trig_lvl),
      .rise_o(),
      .fall_o(trig_fall)
   );

   edge_sync #(.W(3)) u_misc_sync (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({led_enable_switch_i, conn_detect_n_i, stream_clk_i}),
      .level_o(misc_lvl),
      .rise_o(misc_rise),
      .fall_o()
   );

   reg [1:0] ctrl_q, bresp_q, rresp_q;
   reg [15:0] pix_half_q, line_pix_q, line_gap_q;
   reg [15:0] frame_lines_q, stack_frames_q;
   reg [11:0] trig_out_q;
   reg [3:0] evt_q, w_strb_q, untimed_q, raw_evt_q;
   reg [7:0] aw_addr_q, timed_q;
   reg [31:0] w_data_q, rdata_q, wmask, rd_val;
   reg [23:0] out_cnt_q, in_cnt_q;
   reg aw_full_q, w_full_q, bvalid_q, rvalid_q;
   reg out_busy_q, in_busy_q, rd_ok, wr_ok;
   wire do_wr, do_rd, in_done;
   integer i;

   assign s_axi_awready_o = ~aw_full_q;
   assign s_axi_wready_o = ~w_full_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = ~rvalid_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;

   assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
   assign do_rd = s_axi_arvalid_i & ~rvalid_q;
   assign in_done = in_busy_q & (in_cnt_q == 24'h000000);

   always @* begin
      for (i = 0; i < 4; i = i + 1) begin
         wmask[i*8 +: 8] = {8{w_strb_q[i]}};
      end
      case (aw_addr_q)
         `REG_CTRL, `REG_PIX_HALF, `REG_LINE_PIX, `REG_LINE_GAP,
         `REG_FRAME_LINES, `REG_STACK_FRAMES, `REG_TRIG_OUT,
         `REG_TRIG_EVT, `REG_STATUS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // RULE6 no marker readback
   always @* begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr_i)
         `REG_CTRL: rd_val[1:0] = ctrl_q;
         `REG_PIX_HALF: rd_val[15:0] = pix_half_q;
         `REG_LINE_PIX: rd_val[15:0] = line_pix_q;
         `REG_LINE_GAP: rd_val[15:0] = line_gap_q;
         `REG_FRAME_LINES: rd_val[15:0] = frame_lines_q;
         `REG_STACK_FRAMES: rd_val[15:0] = stack_frames_q;
         `REG_TRIG_OUT: rd_val[11:0] = trig_out_q;
         `REG_TRIG_EVT: rd_val[3:0] = evt_q;
         `REG_STATUS: begin
            // RULE13 grounded pin
            rd_val[`STAT_CONN_BIT] = ~misc_lvl[1];
            rd_val[`STAT_RUN_BIT] = ctrl_q[`CTRL_RUN_BIT];
            rd_val[`STAT_LVL_LSB +: 4] = trig_lvl;
            rd_val[`STAT_PEND_BIT] = out_busy_q;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= 2'h0;
      end else begin
         if (s_axi_awvalid_i && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end
         if (do_wr) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? 2'h0 : 2'h2;
         end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
         end
         if (do_rd) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_ok ? 2'h0 : 2'h2;
         end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   wire ev_wr;
   assign ev_wr = do_wr && aw_addr_q == `REG_TRIG_EVT;

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ctrl_q <= `RST_CTRL;
         pix_half_q <= `RST_PIX_HALF;
         line_pix_q <= `RST_LINE_PIX;
         line_gap_q <= `RST_LINE_GAP;
         frame_lines_q <= `RST_FRAME_LINES;
         stack_frames_q <= `RST_STACK_FRAMES;
         trig_out_q <= `RST_TRIG_OUT;
         out_busy_q <= 1'b0;
         out_cnt_q <= 24'h000000;
         timed_q <= 8'h00;
         untimed_q <= 4'h0;
         raw_evt_q <= 4'h0;
         in_busy_q <= 1'b0;
         in_cnt_q <= 24'h000000;
         evt_q <= 4'h0;
      end else begin
         if (do_wr) begin
            case (aw_addr_q)
               `REG_CTRL: ctrl_q <=
                  (ctrl_q & ~wmask[1:0]) | (w_data_q[1:0] & wmask[1:0]);
               `REG_PIX_HALF: pix_half_q <=
                  (pix_half_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
               `REG_LINE_PIX: line_pix_q <=
                  (line_pix_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
               `REG_LINE_GAP: line_gap_q <=
                  (line_gap_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
               `REG_FRAME_LINES: frame_lines_q <= (frame_lines_q
                  & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
               `REG_STACK_FRAMES: stack_frames_q <= (stack_frames_q
                  & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
               default: ;
            endcase
         end
         // RULE11 delayed trigger out
         if (do_wr && aw_addr_q == `REG_TRIG_OUT) begin
            trig_out_q <=
               (trig_out_q & ~wmask[11:0]) | (w_data_q[11:0] & wmask[11:0]);
            out_busy_q <= 1'b1;
            out_cnt_q <= OUT_LAT_CYC;
         end else if (out_busy_q && out_cnt_q != 24'h000000) begin
            out_cnt_q <= out_cnt_q - 24'h000001;
         // RULE7 apply on stream edge
         end else if (out_busy_q && misc_rise[0]) begin
            out_busy_q <= 1'b0;
            timed_q <= trig_out_q[7:0];
         end
         if (out_busy_q && out_cnt_q == 24'h000000) begin
            untimed_q <= trig_out_q[`TRIG_UNTIMED_LSB +: 4];
         end
         // RULE9 RULE10 falling edge capture
         raw_evt_q <= (in_done ? 4'h0 : raw_evt_q) | trig_fall;
         // RULE12 delayed event report
         if (in_done) begin
            in_busy_q <= 1'b0;
         end else if (in_busy_q) begin
            in_cnt_q <= in_cnt_q - 24'h000001;
         end else if ((trig_fall | raw_evt_q) != 4'h0) begin
            in_busy_q <= 1'b1;
            in_cnt_q <= IN_LAT_CYC;
         end
         // RULE8 sticky flag, set wins over clear
         evt_q <= (evt_q & ~(ev_wr ? w_data_q[3:0] & wmask[3:0] : 4'h0))
            | (in_done ? raw_evt_q : 4'h0);
      end
   end

   assign trig_irq_o = |evt_q;
   assign timed_output_o = timed_q;
   assign untimed_output_o = untimed_q;

   reg [15:0] half_cnt_q, line_q, frame_q, nl, nf;
   reg [16:0] pix_q, np;
   reg strobe_q, first_q, line_mk_q, frame_mk_q, stack_mk_q, grab_q;
   wire [16:0] img_start, img_end, line_total;
   wire [15:0] half_lim;
   wire tick;

   assign img_start = {1'b0, `MARKER_LEAD_PIX};
   assign img_end = img_start + {1'b0, line_pix_q};
   assign line_total = img_end + {1'b0, line_gap_q};
   // zero half period would wrap to 16'hffff, so it runs like a half period of one
   assign half_lim = (pix_half_q == 16'h0000) ? 16'h0000
      : pix_half_q - 16'h0001;
   assign tick = half_cnt_q == half_lim;

   always @* begin
      np = pix_q + 17'h00001;
      nl = line_q;
      nf = frame_q;
      if (first_q) begin
         np = 17'h00000;
         nl = 16'h0000;
         nf = 16'h0000;
      end else if (np >= line_total) begin
         np = 17'h00000;
         nl = line_q + 16'h0001;
         if (nl >= frame_lines_q) begin
            nl = 16'h0000;
            nf = frame_q + 16'h0001;
            if (nf >= stack_frames_q) begin
               nf = 16'h0000;
            end
         end
      end
   end

   always @(posedge core_clk_i) begin
      if (sys_rst_i || !ctrl_q[`CTRL_RUN_BIT]) begin
         half_cnt_q <= 16'h0000;
         strobe_q <= 1'b0;
         first_q <= 1'b1;
         pix_q <= 17'h00000;
         line_q <= 16'h0000;
         frame_q <= 16'h0000;
         line_mk_q <= 1'b0;
         frame_mk_q <= 1'b0;
         stack_mk_q <= 1'b0;
         grab_q <= 1'b0;
      end else begin
         // RULE1 equal half periods
         half_cnt_q <= tick ? 16'h0000 : half_cnt_q + 16'h0001;
         if (tick) begin
            strobe_q <= ~strobe_q;
            if (!strobe_q) begin
               first_q <= 1'b0;
               pix_q <= np;
               line_q <= nl;
               frame_q <= nf;
               // RULE2 RULE3 marker on lead pixel
               line_mk_q <= np == 17'h00000;
               frame_mk_q <= np == 17'h00000 && nl == 16'h0000;
               // RULE5 piezo stacks only
               stack_mk_q <= np == 17'h00000 && nl == 16'h0000
                  && nf == 16'h0000 && ctrl_q[`CTRL_PIEZO_BIT];
               // RULE4 capture window
               if (np == img_start && line_pix_q != 16'h0000) begin
                  grab_q <= 1'b1;
               end else if (np == img_end) begin
                  grab_q <= 1'b0;
               end
            end else begin
               // RULE3 one pixel wide
               line_mk_q <= 1'b0;
               frame_mk_q <= 1'b0;
               stack_mk_q <= 1'b0;
            end
         end
      end
   end

   assign pixel_strobe_o = strobe_q;
   assign line_marker_o = line_mk_q;
   assign frame_marker_o = frame_mk_q;
   assign stack_marker_o = stack_mk_q;
   assign grab_window_o = grab_q;

   wire [9:0] mon;
   // RULE18 synced inputs catch >30 ns
   assign mon = {grab_q, strobe_q, timed_q[3:0], trig_lvl};

   genvar g;
   generate
      for (g = 0; g < NUM_LED; g = g + 1) begin : g_led
         // RULE19 common enable switch
         led_activity #(.HOLD_CYC(LED_HOLD_CYC)) u_led (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .sig_i(mon[g % 10]),
            .enable_i(misc_lvl[2]),
            .led_o(led_o[g])
         );
      end
   endgenerate
endmodule

// File: scan_trigger_sync_port_props.sv
// concurrent checks on the pins of the trigger port
`timescale 1ns/1ns
module scan_trigger_sync_port_props #(
   parameter [23:0] OUT_LAT_CYC = 24'd20,
   parameter [23:0] IN_LAT_CYC = 24'd20,
   parameter NUM_LED = 10
) (
   input wire core_clk_i,
   input wire sys_rst_i,
   input wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire [31:0] s_axi_rdata_o,
   input wire [3:0] trigger_input_i,
   input wire led_enable_switch_i,
   input wire pixel_strobe_o,
   input wire line_marker_o,
   input wire frame_marker_o,
   input wire stack_marker_o,
   input wire grab_window_o,
   input wire [7:0] timed_output_o,
   input wire [3:0] untimed_output_o,
   input wire trig_irq_o,
   input wire [NUM_LED-1:0] led_o
);
   localparam int IN_HI = IN_LAT_CYC + 12;
   logic [15:0] run_q, hi_q;
   logic [7:0] pix_q;
   logic hv_q, stb_q;
   wire stb_rise = pixel_strobe_o & ~stb_q;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // run length of each strobe level, and pixels since the line marker
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         run_q <= 16'h0;
         hi_q <= 16'h0;
         hv_q <= 1'b0;
         stb_q <= 1'b0;
         pix_q <= 8'h0;
      end else begin
         stb_q <= pixel_strobe_o;
         run_q <= (pixel_strobe_o != stb_q) ? 16'h1 : run_q + 16'h1;
         if (stb_q && !pixel_strobe_o) begin
            hi_q <= run_q;
            hv_q <= 1'b1;
         end
         if (stb_rise) begin
            pix_q <= line_marker_o ? 8'h0 : pix_q + 8'h1;
         end
      end
   end
   a_strobe_symm: assert property (stb_rise && hv_q |-> run_q == hi_q)
      else $error("strobe low and high halves differ");
   a_marker_shape: assert property ((line_marker_o || frame_marker_o ||
      stack_marker_o) |-> pixel_strobe_o)
      else $error("marker outside strobe high");
   a_marker_rise: assert property ($rose(line_marker_o) |-> stb_rise)
      else $error("marker rise off strobe rise");
   a_marker_fall: assert property ($fell(line_marker_o) |->
      $fell(pixel_strobe_o))
      else $error("marker fall off strobe fall");
   a_frame_on_line: assert property (frame_marker_o |-> line_marker_o)
      else $error("frame marker without line marker");
   a_stack_on_frame: assert property (stack_marker_o |-> frame_marker_o)
      else $error("stack marker without frame marker");
   a_grab_lead: assert property ($rose(grab_window_o) |->
      stb_rise && pix_q == 8'd15)
      else $error("grab window not 16 pixels after marker");
   a_irq_timely: assert property ((|($past(trigger_input_i) &
      ~trigger_input_i)) && !trig_irq_o |-> ##[1:IN_HI] trig_irq_o)
      else $error("no interrupt after falling trigger");
   a_irq_not_early: assert property ((|($past(trigger_input_i) &
      ~trigger_input_i)) && !trig_irq_o |-> !trig_irq_o [*8])
      else $error("interrupt before latency");
   a_timed_follow: assert property ($changed(untimed_output_o) |->
      ##[0:16] $changed(timed_output_o))
      else $error("timed outputs did not follow");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped before handshake");
   a_leds_dark: assert property (!led_enable_switch_i [*4] |->
      led_o == '0)
      else $error("led lit while switched off");
endmodule
bind scan_trigger_sync_port scan_trigger_sync_port_props #(
   .OUT_LAT_CYC(OUT_LAT_CYC), .IN_LAT_CYC(IN_LAT_CYC), .NUM_LED(NUM_LED)
) props (.*);

// File: scan_trigger_far_end.sv
// far side: pulse generator, host stream clock and connector plug
`timescale 1ns/1ns
module scan_trigger_far_end (
   output logic stream_clk_o,
   output logic [3:0] trig_o,
   output logic conn_n_o
);
   // pulled-up inputs idle high; stream clock runs free
   initial begin
      trig_o = 4'hf;
      conn_n_o = 1'b1;
      stream_clk_o = 1'b0;
      #3;
      forever #40 stream_clk_o = ~stream_clk_o;
   end
   // low pulse kept over 50 ns
   task automatic pulse(input int idx, input int w_ns);
      trig_o[idx] = 1'b0;
      #(w_ns > 50 ? w_ns : 51);
      trig_o[idx] = 1'b1;
   endtask
   task automatic plug(input logic on);
      conn_n_o = ~on;
   endtask
endmodule

// File: scan_trigger_sync_port_bench.sv
// self-checking bench of the trigger port
`timescale 1ns/1ns
`include "scan_trigger_sync_port_map.vh"
module scan_trigger_sync_port_bench;
   logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, rry = 0, sw = 1;
   logic bry = 1, cnt_on = 0, lm_q = 0, fm_q = 0, sm_q = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rnd = 32'd10;
   logic [11:0] old, nv;
   wire awr, wrdy, bv, arr, rv, strb, lm, fm, sm, gw, irq, sclk, cn;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   wire [7:0] to;
   wire [3:0] uo, ti;
   wire [9:0] led;
   int err_total = 0, cmp_count = 0, lines, frames, stacks, glen = 0;
   int n, k;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   scan_trigger_sync_port #(.OUT_LAT_CYC(24'd20), .IN_LAT_CYC(24'd20),
      .LED_HOLD_CYC(26'd50)) DUT (
      .core_clk_i(clk), .sys_rst_i(rst), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
      .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
      .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rdat),
      .s_axi_rresp_o(rr), .stream_clk_i(sclk), .trigger_input_i(ti),
      .conn_detect_n_i(cn), .led_enable_switch_i(sw),
      .pixel_strobe_o(strb), .line_marker_o(lm), .frame_marker_o(fm),
      .stack_marker_o(sm), .grab_window_o(gw), .timed_output_o(to),
      .untimed_output_o(uo), .trig_irq_o(irq), .led_o(led));
   scan_trigger_far_end far (.stream_clk_o(sclk), .trig_o(ti),
      .conn_n_o(cn));
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic gate(input int cnt, input int lim);
      if (cnt >= lim) begin
         err_total++;
         $display("unexpected at %0t: wait ran out", $time);
         summarize();
      end
   endtask
   // bready stays high, so a response is taken as soon as it shows
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      int i;
      bq.push_back(r);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      for (i = 0; i < 200; i++) begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
         if (bv) break;
      end
      gate(i, 200);
   endtask
   // rready raised late on purpose so read data must stand
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      int i;
      rq.push_back({r, d});
      ara <= a;
      arv <= 1;
      for (i = 0; i < 200; i++) begin
         @(posedge clk);
         if (arr) arv <= 0;
         if (rv && rry) break;
         if (rv) rry <= 1;
      end
      rry <= 0;
      gate(i, 200);
   endtask
   task automatic scan_count(input int el, input int ef, input int es);
      for (n = 0; n < 500 && lm !== 1'b1; n++) @(posedge clk);
      gate(n, 500);
      repeat (2) @(posedge clk);
      lines = 0;
      frames = 0;
      stacks = 0;
      cnt_on <= 1;
      repeat (704) @(posedge clk);
      cnt_on <= 0;
      chk(lines, el);
      chk(frames, ef);
      chk(stacks, es);
   endtask
   always @(posedge clk) begin
      lm_q <= lm;
      fm_q <= fm;
      sm_q <= sm;
      if (cnt_on && lm && !lm_q) lines++;
      if (cnt_on && fm && !fm_q) frames++;
      if (cnt_on && sm && !sm_q) stacks++;
      if (gw === 1'b1) glen++;
      else if (glen != 0) begin
         chk(glen, 16);
         glen = 0;
      end
      if (bv && bry) chk(br, bq.pop_front());
      if (rv && rry) chk({rr, rdat}, rq.pop_front());
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd_reg(`REG_CTRL, `RST_CTRL, 2'h0);
      rd_reg(`REG_PIX_HALF, `RST_PIX_HALF, 2'h0);
      rd_reg(`REG_LINE_PIX, `RST_LINE_PIX, 2'h0);
      rd_reg(`REG_LINE_GAP, `RST_LINE_GAP, 2'h0);
      rd_reg(`REG_FRAME_LINES, `RST_FRAME_LINES, 2'h0);
      rd_reg(`REG_STACK_FRAMES, `RST_STACK_FRAMES, 2'h0);
      rd_reg(8'h40, 32'h0, 2'h2);
      wr_reg(8'h40, 32'h1, 2'h2);
      $display("test registers done");
      wr_reg(`REG_PIX_HALF, 32'h2, 2'h0);
      wr_reg(`REG_LINE_PIX, 32'h4, 2'h0);
      wr_reg(`REG_LINE_GAP, 32'h2, 2'h0);
      wr_reg(`REG_FRAME_LINES, 32'h2, 2'h0);
      wr_reg(`REG_STACK_FRAMES, 32'h2, 2'h0);
      wr_reg(`REG_CTRL, 32'h3, 2'h0);
      scan_count(8, 4, 2);
      wr_reg(`REG_CTRL, 32'h1, 2'h0);
      scan_count(8, 4, 0);
      $display("test scan done");
      old = 12'h0;
      for (k = 0; k < 3; k++) begin
         rnd = xs(rnd);
         nv = old ^ (rnd[11:0] | 12'h101);
         wr_reg(`REG_TRIG_OUT, {20'h0, nv}, 2'h0);
         for (n = 0; n < 200 && uo === old[11:8]; n++) @(posedge clk);
         chk(n >= 15 && n <= 22, 1);
         chk(uo, nv[11:8]);
         for (n = 0; n < 40 && to !== nv[7:0]; n++) @(posedge clk);
         chk(to, nv[7:0]);
         rd_reg(`REG_TRIG_OUT, {20'h0, nv}, 2'h0);
         old = nv;
      end
      $display("test trigger outputs done");
      for (k = 0; k < 4; k++) begin
         far.pulse(k, 60);
         for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk);
         chk(irq, 1);
         rd_reg(`REG_TRIG_EVT, 32'h1 << k, 2'h0);
         wr_reg(`REG_TRIG_EVT, 32'h1 << k, 2'h0);
         repeat (2) @(posedge clk);
         chk(irq, 0);
      end
      $display("test trigger inputs done");
      rd_reg(`REG_STATUS, 32'h3e, 2'h0);
      far.plug(1);
      repeat (5) @(posedge clk);
      rd_reg(`REG_STATUS, 32'h3f, 2'h0);
      $display("test status done");
      sw <= 0;
      repeat (6) @(posedge clk);
      chk(led, 0);
      sw <= 1;
      repeat (120) @(posedge clk);
      chk(led[0], 1);
      far.pulse(0, 60);
      repeat (10) @(posedge clk);
      chk(led[0], 0);
      repeat (60) @(posedge clk);
      chk(led[0], 1);
      $display("test leds done");
      summarize();
   end
endmodule
